// ===== rtl/rlc_defs.svh
`ifndef RLC_DEFS_SVH
`define RLC_DEFS_SVH

// Register indices; byte address is four times the index
`define RLC_IDX_RADIO_CTRL    8'hC2
`define RLC_IDX_RADIO_MAIN    8'hC9
`define RLC_IDX_CHAN_A_LOW    8'hCA
`define RLC_IDX_CHAN_A_MID    8'hCB
`define RLC_IDX_CHAN_A_HIGH   8'hCC
`define RLC_IDX_CHAN_B_LOW    8'hCD
`define RLC_IDX_CHAN_B_MID    8'hCE
`define RLC_IDX_CHAN_B_HIGH   8'hCF
`define RLC_IDX_DATA_BUF      8'hD9
`define RLC_IDX_MODEM_CFG     8'hDB
`define RLC_IDX_SYNTH_CTRL    8'hE3
`define RLC_IDX_SEP_LOW       8'hEA
`define RLC_IDX_SEP_HIGH      8'hEB

// Radio control fields
`define RLC_RC_VIOL_BIT       4
`define RLC_RC_LIMIT_LSB      1
`define RLC_RC_BYTEMODE_BIT   0
// Radio main fields
`define RLC_RM_TX_MODE_BIT    0
`define RLC_RM_CHAN_SEL_BIT   1
`define RLC_RM_HIGH_SIDE_BIT  2
`define RLC_RM_TX_BUSY_BIT    3
`define RLC_RM_TX_FULL_BIT    4
// Synthesizer control fields
`define RLC_SC_REFDIV_LSB     3
`define RLC_SC_ALARM_DIS_BIT  2
`define RLC_SC_ALARM_H_BIT    1
`define RLC_SC_ALARM_L_BIT    0

// Reset values
`define RLC_RST_LIMIT         3'h0
`define RLC_RST_REFDIV        5'h02
`define RLC_RST_ALARM_DIS     1'b1
`define RLC_RST_CHAN_WORD     24'h40_0000
`define RLC_RST_SEP_WORD      11'h000

// Timing and arithmetic counts
`define RLC_HALF_SAMPLES      4'd7
`define RLC_MAJORITY          3'd4
`define RLC_DIVIDE_OFFSET     25'h000_2000
`define RLC_REFDIV_MIN        5'd2
`define RLC_REFDIV_MAX        5'd24

`endif

// ===== rtl/rlc_pkg.sv
package rlc_pkg;

    // Transmit shifter states, Gray ordered along idle-first-second
    typedef enum logic [1:0] {
        rlc_tx_idle   = 2'b00,
        rlc_tx_first  = 2'b01,
        rlc_tx_second = 2'b11
    } rlc_tx_state_t;

    // Reference divider state
    typedef struct packed {
        logic [4:0] count;
        logic       tick;
    } rlc_refdiv_state_t;

    // Whole state of the control block
    typedef struct packed {
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        logic [2:0]    limit;
        logic          bytemode;
        logic          viol;
        logic          fmt_pend;
        logic          fmt_rx;
        logic          tx_mode;
        logic          chan_sel;
        logic          high_side;
        logic [23:0]   chan_a;
        logic [23:0]   chan_b;
        logic [10:0]   sep;
        logic [4:0]    refdiv;
        logic          alarm_dis;
        logic          alarm_h;
        logic          alarm_l;
        logic [3:0]    smp_cnt;
        logic [2:0]    ones;
        logic [2:0]    ones_a;
        logic          half;
        logic [7:0]    rx_shift;
        logic [2:0]    rx_bits;
        logic          rx_acc;
        logic [7:0]    rx_buf;
        rlc_tx_state_t txst;
        logic [7:0]    tx_pend;
        logic          tx_pend_fmt;
        logic          tx_pend_vld;
        logic [7:0]    tx_shift;
        logic          tx_fmt;
        logic [2:0]    tx_left;
        logic          tx_chip;
        logic          tx_out;
        logic          irq;
        logic [24:0]   divide;
    } rlc_top_state_t;

endpackage

// ===== rtl/rlc_refdiv.sv
`timescale 1ns/100ps
`include "rlc_defs.svh"

// Divides the crystal clock into a one-cycle reference tick
module rlc_refdiv #(
    parameter int MIN_DIV = 2,
    parameter int MAX_DIV = 24
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Divider setting
    input  wire logic [4:0] div,
    // Reference tick
    output logic            ref_tick
);

    generate
        if (MIN_DIV < 2 || MAX_DIV > 31 || MIN_DIV > MAX_DIV) begin : g_bad
            $error("rlc_refdiv: divider range not supported");
        end
    endgenerate

    rlc_pkg::rlc_refdiv_state_t r;
    rlc_pkg::rlc_refdiv_state_t n;

    // Out-of-range settings are clamped so the tick never stalls
    always_comb begin
        logic [4:0] eff;
        eff = div;
        if (div < 5'(MIN_DIV)) begin
            eff = 5'(MIN_DIV);
        end else if (div > 5'(MAX_DIV)) begin
            eff = 5'(MAX_DIV);
        end
        n = r;
        n.tick = 1'b0;
        if (r.count >= eff - 5'd1) begin
            n.count = 5'd0;
            n.tick = 1'b1;
        end else begin
            n.count = r.count + 5'd1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign ref_tick = r.tick;

endmodule

// ===== rtl/rlc_top.sv
`timescale 1ns/100ps
`include "rlc_defs.svh"

module rlc_top #(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Demodulator samples, 14 per Manchester symbol
    input  wire logic              rx_sample_valid,
    input  wire logic              rx_sample,
    // Transmit chip timing and modulator data
    input  wire logic              tx_chip_tick,
    output logic                   transmit_bit,
    // Synthesizer
    input  wire logic              tune_high,
    input  wire logic              tune_low,
    output logic [24:0]            synth_divide,
    output logic                   ref_tick,
    // Radio event
    output logic                   rf_irq
);

    generate
        if (ADDR_W < 10) begin : g_bad
            $error("rlc_top: address bus too narrow for the register map");
        end
    endgenerate

    rlc_pkg::rlc_top_state_t r;
    rlc_pkg::rlc_top_state_t n;

    always_comb begin
        logic       setup;
        logic       acc;
        logic [7:0] idx;
        logic       hit;
        logic [7:0] rd;
        logic [7:0] wd;
        logic [2:0] ones_now;
        logic [2:0] bal;
        logic       rvalid;
        logic       rbit;
        logic       rviol;
        logic [7:0] sh;
        logic       do_load;
        logic [23:0] chan;
        setup = psel & ~penable;
        acc = psel & penable & r.pready;
        idx = paddr[9:2];
        hit = 1'b1;
        rd = 8'h00;
        wd = pwdata[7:0];
        ones_now = 3'h0;
        bal = 3'h0;
        rvalid = 1'b0;
        rbit = 1'b0;
        rviol = 1'b0;
        sh = 8'h00;
        do_load = 1'b0;
        chan = 24'h00_0000;
        n = r;
        n.pready = 1'b0;
        n.irq = 1'b0;

        // Read mux; written fields read back, except the data buffer, which returns the receive byte
        unique case (idx)
            `RLC_IDX_RADIO_CTRL: rd = {3'b000, r.viol, r.limit, r.bytemode};
            `RLC_IDX_RADIO_MAIN: rd = {3'b000, r.tx_pend_vld,
                                       r.txst != rlc_pkg::rlc_tx_idle,
                                       r.high_side, r.chan_sel, r.tx_mode};
            `RLC_IDX_CHAN_A_LOW:  rd = r.chan_a[7:0];
            `RLC_IDX_CHAN_A_MID:  rd = r.chan_a[15:8];
            `RLC_IDX_CHAN_A_HIGH: rd = r.chan_a[23:16];
            `RLC_IDX_CHAN_B_LOW:  rd = r.chan_b[7:0];
            `RLC_IDX_CHAN_B_MID:  rd = r.chan_b[15:8];
            `RLC_IDX_CHAN_B_HIGH: rd = r.chan_b[23:16];
            `RLC_IDX_DATA_BUF:    rd = r.rx_buf;
            `RLC_IDX_MODEM_CFG:   rd = {7'h00, r.fmt_pend};
            `RLC_IDX_SYNTH_CTRL:  rd = {r.refdiv, r.alarm_dis, r.alarm_h, r.alarm_l};
            `RLC_IDX_SEP_LOW:     rd = r.sep[7:0];
            `RLC_IDX_SEP_HIGH:    rd = {5'h00, r.sep[10:8]};
            default:              hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00 || (paddr >> 10) != '0) begin
            hit = 1'b0;
        end

        // Answer is staged in setup so pready and data leave flip-flops
        if (setup) begin
            n.pready = 1'b1;
            n.pslverr = ~hit;
            n.prdata = hit ? {24'h00_0000, rd} : 32'h0000_0000;
        end

        // Writes commit on the access edge only
        if (acc && pwrite && !r.pslverr) begin
            unique case (idx)
                `RLC_IDX_RADIO_CTRL: begin
                    n.limit = wd[`RLC_RC_LIMIT_LSB +: 3];
                    n.bytemode = wd[`RLC_RC_BYTEMODE_BIT];
                end
                `RLC_IDX_RADIO_MAIN: begin
                    n.tx_mode = wd[`RLC_RM_TX_MODE_BIT];
                    n.chan_sel = wd[`RLC_RM_CHAN_SEL_BIT];
                    n.high_side = wd[`RLC_RM_HIGH_SIDE_BIT];
                end
                `RLC_IDX_CHAN_A_LOW:  n.chan_a[7:0] = wd;
                `RLC_IDX_CHAN_A_MID:  n.chan_a[15:8] = wd;
                `RLC_IDX_CHAN_A_HIGH: n.chan_a[23:16] = wd;
                `RLC_IDX_CHAN_B_LOW:  n.chan_b[7:0] = wd;
                `RLC_IDX_CHAN_B_MID:  n.chan_b[15:8] = wd;
                `RLC_IDX_CHAN_B_HIGH: n.chan_b[23:16] = wd;
                `RLC_IDX_DATA_BUF: begin
                    // Coding choice travels with the byte it was written with
                    if (r.tx_mode) begin
                        n.tx_pend = wd;
                        n.tx_pend_fmt = r.fmt_pend;
                        n.tx_pend_vld = 1'b1;
                    end
                end
                `RLC_IDX_MODEM_CFG:  n.fmt_pend = wd[0];
                `RLC_IDX_SYNTH_CTRL: begin
                    n.refdiv = wd[`RLC_SC_REFDIV_LSB +: 5];
                    n.alarm_dis = wd[`RLC_SC_ALARM_DIS_BIT];
                end
                `RLC_IDX_SEP_LOW:  n.sep[7:0] = wd;
                `RLC_IDX_SEP_HIGH: n.sep[10:8] = wd[2:0];
                default: ;
            endcase
        end

        // Receive: 7-sample halves; NRZ bit per half, Manchester per pair
        if (!r.tx_mode && rx_sample_valid) begin
            ones_now = r.ones + {2'b00, rx_sample};
            if (r.smp_cnt == `RLC_HALF_SAMPLES - 4'd1) begin
                n.smp_cnt = 4'd0;
                n.ones = 3'h0;
                if (!r.fmt_rx) begin
                    rvalid = 1'b1;
                    rbit = ones_now >= `RLC_MAJORITY;
                end else if (!r.half) begin
                    n.half = 1'b1;
                    n.ones_a = ones_now;
                end else begin
                    n.half = 1'b0;
                    rvalid = 1'b1;
                    // Best guess wins even for a weak symbol
                    rbit = r.ones_a > ones_now;
                    bal = (r.ones_a > ones_now) ? r.ones_a - ones_now
                                                : ones_now - r.ones_a;
                    rviol = (r.limit != 3'h0) && (bal < r.limit);
                end
            end else begin
                n.smp_cnt = r.smp_cnt + 4'd1;
                n.ones = ones_now;
            end
        end
        rbit = rbit ^ r.high_side;

        // Present bits or bytes to software
        if (rvalid) begin
            if (r.bytemode) begin
                sh = {r.rx_shift[6:0], rbit};
                if (r.rx_bits == 3'd7) begin
                    n.rx_buf = sh;
                    n.viol = r.rx_acc | rviol;
                    n.rx_acc = 1'b0;
                    n.rx_bits = 3'd0;
                    n.irq = 1'b1;
                end else begin
                    n.rx_shift = sh;
                    n.rx_acc = r.rx_acc | rviol;
                    n.rx_bits = r.rx_bits + 3'd1;
                end
            end else begin
                n.rx_buf = {r.rx_buf[7:1], rbit};
                n.viol = rviol;
                n.irq = 1'b1;
            end
        end
        // Receive coding only switches at a radio event
        if (!r.tx_mode && n.irq) begin
            n.fmt_rx = r.fmt_pend;
        end

        // Transmit shifter; Manchester sends bit then its complement
        if (r.tx_mode && tx_chip_tick) begin
            unique case (r.txst)
                rlc_pkg::rlc_tx_idle: begin
                    do_load = r.tx_pend_vld;
                end
                rlc_pkg::rlc_tx_first: begin
                    if (r.tx_fmt) begin
                        n.tx_chip = ~r.tx_shift[7];
                        n.txst = rlc_pkg::rlc_tx_second;
                    end else if (r.tx_left != 3'd0) begin
                        n.tx_shift = {r.tx_shift[6:0], 1'b0};
                        n.tx_left = r.tx_left - 3'd1;
                        n.tx_chip = r.tx_shift[6];
                    end else begin
                        do_load = r.tx_pend_vld;
                        n.txst = rlc_pkg::rlc_tx_idle;
                    end
                end
                rlc_pkg::rlc_tx_second: begin
                    if (r.tx_left != 3'd0) begin
                        n.tx_shift = {r.tx_shift[6:0], 1'b0};
                        n.tx_left = r.tx_left - 3'd1;
                        n.tx_chip = r.tx_shift[6];
                        n.txst = rlc_pkg::rlc_tx_first;
                    end else begin
                        do_load = r.tx_pend_vld;
                        n.txst = rlc_pkg::rlc_tx_idle;
                    end
                end
                default: n.txst = rlc_pkg::rlc_tx_idle;
            endcase
        end
        // Coding is taken only when a byte enters the shifter
        if (do_load) begin
            n.tx_shift = r.bytemode ? r.tx_pend : {r.tx_pend[0], 7'h00};
            n.tx_fmt = r.tx_pend_fmt;
            n.tx_left = r.bytemode ? 3'd7 : 3'd0;
            n.tx_chip = r.bytemode ? r.tx_pend[7] : r.tx_pend[0];
            n.tx_pend_vld = 1'b0;
            n.txst = rlc_pkg::rlc_tx_first;
            n.irq = 1'b1;
        end
        if (!n.tx_mode) begin
            n.txst = rlc_pkg::rlc_tx_idle;
        end

        // Tuning alarms, gated by the inhibit bit
        n.alarm_h = ~r.alarm_dis & tune_high;
        n.alarm_l = ~r.alarm_dis & tune_low;

        // Modulator bit is zero whenever the radio receives
        n.tx_out = n.tx_mode & n.tx_chip;
        chan = n.chan_sel ? n.chan_b : n.chan_a;
        n.divide = {1'b0, chan} + `RLC_DIVIDE_OFFSET
                 + (n.tx_out ? {14'h0000, n.sep} : 25'h000_0000);
    end

    // Single state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.limit <= `RLC_RST_LIMIT;
            r.refdiv <= `RLC_RST_REFDIV;
            r.alarm_dis <= `RLC_RST_ALARM_DIS;
            r.chan_a <= `RLC_RST_CHAN_WORD;
            r.chan_b <= `RLC_RST_CHAN_WORD;
            r.sep <= `RLC_RST_SEP_WORD;
            r.divide <= 25'h040_2000;
        end else begin
            r <= n;
        end
    end

    // Reference tick from the divider, registered inside it
    rlc_refdiv #(
        .MIN_DIV (int'(`RLC_REFDIV_MIN)),
        .MAX_DIV (int'(`RLC_REFDIV_MAX))
    ) u_refdiv (
        .clk      (clk),
        .rstn     (rstn),
        .div      (r.refdiv),
        .ref_tick (ref_tick)
    );

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign transmit_bit = r.tx_out;
    assign synth_divide = r.divide;
    assign rf_irq = r.irq;

endmodule

// ===== tb/rlc_top_props.sv
`timescale 1ns/100ps

// Pin-level watcher for the line coding and synthesizer control block
module rlc_top_props #(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Radio side
    input wire logic              rx_sample_valid,
    input wire logic              tx_chip_tick,
    input wire logic              transmit_bit,
    input wire logic              ref_tick,
    input wire logic              rf_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Steps shared by the bus and divider checks
    sequence s_setup; psel && !penable; endsequence
    sequence s_gap; !ref_tick ##[1:23] ref_tick; endsequence

    property p_setup_answer; s_setup |=> pready; endproperty
    a_setup_answer: assert property (p_setup_answer) else $error("no answer");
    property p_ready_pulse; pready |-> psel && penable ##1 !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("bad pready");
    property p_misalign;
        s_setup ##0 (paddr[1:0] != 2'b00) |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned taken");
    property p_data_hold; $changed(prdata) |-> $past(psel && !penable); endproperty
    a_data_hold: assert property (p_data_hold) else $error("prdata moved");
    property p_irq_pulse; rf_irq |=> !rf_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
    // An event follows a chip tick or a decoded sample by one edge
    property p_irq_cause;
        rf_irq |-> $past(tx_chip_tick) || $past(rx_sample_valid);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq uncaused");
    property p_ref_period; ref_tick |=> s_gap; endproperty
    a_ref_period: assert property (p_ref_period) else $error("bad ref gap");
    // Chip level only moves on a chip tick or a mode write
    property p_tx_stable;
        $changed(transmit_bit) |->
            $past(tx_chip_tick) || $past(pwrite && penable) || $past(pwrite && penable, 2);
    endproperty
    a_tx_stable: assert property (p_tx_stable) else $error("chip moved");
endmodule

bind rlc_top rlc_top_props #(.ADDR_W(ADDR_W)) u_props (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_sample_valid(rx_sample_valid), .tx_chip_tick(tx_chip_tick),
    .transmit_bit(transmit_bit), .ref_tick(ref_tick), .rf_irq(rf_irq)
);

// ===== tb/rlc_radio_model.sv
`timescale 1ns/100ps

// Far-side radio: demodulator sample stream and modulator chip timing
module rlc_radio_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Requests from the bench
    input  wire logic       sym_go,
    input  wire logic       sym_man,
    input  wire logic       sym_val,
    input  wire logic [2:0] sym_flip,
    input  wire logic       tick_go,
    // Block side
    input  wire logic       transmit_bit,
    output logic            rx_sample_valid,
    output logic            rx_sample,
    output logic            tx_chip_tick,
    // Status to the bench
    output logic            busy,
    output logic [23:0]     tx_cap
);
    logic       sbusy;
    logic       ph;
    logic       tick_d;
    logic [3:0] sn;
    logic [4:0] tn;
    logic [1:0] tc;

    assign busy = sbusy || (tn != 5'd0);

    // Line toggles between samples so a stale level is never mistaken for data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {sbusy, ph, tick_d, rx_sample_valid, rx_sample, tx_chip_tick} <= '0;
            {sn, tn, tc, tx_cap} <= '0;
        end else begin
            rx_sample_valid <= 1'b0;
            tx_chip_tick    <= 1'b0;
            ph              <= ~ph;
            tick_d          <= tx_chip_tick;
            tc              <= tc + 2'd1;
            if (tick_d) begin
                tx_cap <= {tx_cap[22:0], transmit_bit};
            end
            if (sym_go) begin
                sbusy <= 1'b1;
                sn    <= 4'd0;
            end else if (sbusy && ph) begin
                rx_sample_valid <= 1'b1;
                // First half carries the bit with some samples spoiled to unbalance it
                rx_sample <= (sn < 4'd7) ? (sym_val ^ (sn < {1'b0, sym_flip})) : ~sym_val;
                sn        <= sn + 4'd1;
                if (sn == (sym_man ? 4'd13 : 4'd6)) begin
                    sbusy <= 1'b0;
                end
            end else begin
                rx_sample <= ~rx_sample;
            end
            // Chip ticks run only for a frame of 24 chips
            if (tick_go) begin
                tn <= 5'd24;
                tc <= 2'd0;
            end else if (tn != 5'd0 && tc == 2'd3) begin
                tx_chip_tick <= 1'b1;
                tn           <= tn - 5'd1;
            end
        end
    end
endmodule

// ===== tb/rlc_top_tb.sv
`timescale 1ns/100ps
`include "rlc_defs.svh"

// Register, receive and transmit sequences against fixed expectations
module rlc_top_tb;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic        rxv, rxs, tick, tbit, tune_h, tune_l, refk, irq;
    logic        go, man, val, tgo, busy;
    logic [2:0]  flip;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [24:0] div;
    logic [23:0] cap;
    logic [7:0]  rd;
    logic [7:0]  cw [6];
    int          error_cnt, num_checks, irqs, t;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    rlc_top i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_sample_valid(rxv), .rx_sample(rxs), .tx_chip_tick(tick), .transmit_bit(tbit),
        .tune_high(tune_h), .tune_low(tune_l), .synth_divide(div), .ref_tick(refk),
        .rf_irq(irq));
    rlc_radio_model i_radio (.clk(clk), .rstn(rstn), .sym_go(go), .sym_man(man),
        .sym_val(val), .sym_flip(flip), .tick_go(tgo), .transmit_bit(tbit),
        .rx_sample_valid(rxv), .rx_sample(rxs), .tx_chip_tick(tick), .busy(busy),
        .tx_cap(cap));

    // Event count lets waits survive an event that lands before the wait starts
    always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; holds everything until pready is seen
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd      = prdata[7:0];
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, {i, 2'b00}, d);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] i, input logic [7:0] e);
        apb(1'b0, {i, 2'b00}, 8'h00);
        check(nm, 32'(e), 32'(rd));
    endtask

    // One symbol from the far side, then wait for its samples to finish
    task automatic sym(input logic m, input logic v, input logic [2:0] f);
        @(posedge clk);
        go   <= 1'b1;
        man  <= m;
        val  <= v;
        flip <= f;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy === 1'b1);
    endtask

    task automatic rxbyte(input logic m, input logic [7:0] b, input int vb, input int k);
        for (int i = 7; i >= 0; i--) sym(m, b[i], (i == vb) ? 3'd5 : 3'd0);
        while (irqs < k) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog: the full sequence needs well under 10000 cycles
    initial begin
        #400000;
        error_cnt++;
        complete_run();
    end

    initial begin
        {rstn, psel, penable, pwrite, tune_h, tune_l, go, man, val, tgo} = '0;
        {paddr, pwdata, flip} = '0;
        {error_cnt, num_checks, irqs} = '0;
        cw = '{8'h33, 8'h22, 8'h41, 8'h02, 8'h01, 8'h50};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check("divide_rst", 32'h0040_2000, 32'(div));
        rdchk("synth_rst", `RLC_IDX_SYNTH_CTRL, 8'h14);
        apb(1'b0, {`RLC_IDX_CHAN_A_LOW, 2'b01}, 8'h00);
        check("misaligned", 32'h1, 32'(err));
        for (int i = 0; i < 6; i++) wr(8'(`RLC_IDX_CHAN_A_LOW + i), cw[i]);
        for (int i = 0; i < 6; i++) rdchk("chan", 8'(`RLC_IDX_CHAN_A_LOW + i), cw[i]);
        check("divide_a", 32'h0041_4233, 32'(div));
        wr(`RLC_IDX_RADIO_MAIN, 8'h02);
        repeat (2) @(posedge clk);
        check("divide_b", 32'h0050_2102, 32'(div));
        wr(`RLC_IDX_SEP_HIGH, 8'hFF);
        wr(`RLC_IDX_SEP_LOW, 8'h10);
        rdchk("sep_high", `RLC_IDX_SEP_HIGH, 8'h07);
        // Reference divider of 5 with alarms enabled
        wr(`RLC_IDX_SYNTH_CTRL, 8'h28);
        tune_h <= 1'b1;
        repeat (30) @(posedge clk);
        do @(posedge clk); while (refk !== 1'b1);
        t = 0;
        do begin @(posedge clk); t++; end while (refk !== 1'b1);
        check("ref_period", 32'd5, 32'(t));
        rdchk("alarm_h", `RLC_IDX_SYNTH_CTRL, 8'h2A);
        tune_h <= 1'b0;
        tune_l <= 1'b1;
        rdchk("alarm_l", `RLC_IDX_SYNTH_CTRL, 8'h29);
        wr(`RLC_IDX_SYNTH_CTRL, 8'h2C);
        rdchk("alarm_off", `RLC_IDX_SYNTH_CTRL, 8'h2C);
        // Receive: NRZ sync byte, then Manchester once the event has passed
        wr(`RLC_IDX_RADIO_MAIN, 8'h00);
        wr(`RLC_IDX_RADIO_CTRL, 8'h07);
        wr(`RLC_IDX_MODEM_CFG, 8'h01);
        rxbyte(1'b0, 8'hC5, 8, 1);
        rdchk("sync_byte", `RLC_IDX_DATA_BUF, 8'hC5);
        rxbyte(1'b1, 8'h96, 3, 2);
        rdchk("man_byte", `RLC_IDX_DATA_BUF, 8'h96);
        rdchk("viol_byte", `RLC_IDX_RADIO_CTRL, 8'h17);
        wr(`RLC_IDX_RADIO_MAIN, 8'h04);
        wr(`RLC_IDX_RADIO_CTRL, 8'h01);
        rxbyte(1'b1, 8'h96, 3, 3);
        rdchk("inverted", `RLC_IDX_DATA_BUF, 8'h69);
        rdchk("viol_dis", `RLC_IDX_RADIO_CTRL, 8'h01);
        wr(`RLC_IDX_RADIO_MAIN, 8'h00);
        wr(`RLC_IDX_RADIO_CTRL, 8'h06);
        rxbyte(1'b1, 8'h01, 0, 11);
        apb(1'b0, {`RLC_IDX_DATA_BUF, 2'b00}, 8'h00);
        check("bit_one", 32'h1, 32'(rd[0]));
        rdchk("viol_bit", `RLC_IDX_RADIO_CTRL, 8'h16);
        sym(1'b1, 1'b0, 3'd4);
        while (irqs < 12) @(posedge clk);
        rdchk("viol_edge", `RLC_IDX_RADIO_CTRL, 8'h06);
        // Transmit: NRZ byte, then a Manchester byte queued mid-shift
        wr(`RLC_IDX_RADIO_MAIN, 8'h03);
        wr(`RLC_IDX_RADIO_CTRL, 8'h07);
        wr(`RLC_IDX_MODEM_CFG, 8'h00);
        wr(`RLC_IDX_DATA_BUF, 8'hA5);
        tgo <= 1'b1;
        @(posedge clk);
        tgo <= 1'b0;
        while (irqs < 13) @(posedge clk);
        check("divide_tone", 32'h0050_2812, 32'(div));
        wr(`RLC_IDX_MODEM_CFG, 8'h01);
        wr(`RLC_IDX_DATA_BUF, 8'h0F);
        do @(posedge clk); while (busy === 1'b1);
        // Last chip is captured two edges after the model goes idle
        repeat (2) @(posedge clk);
        check("tx_chips", 32'h00A5_55AA, 32'(cap));
        // Bitmode sends data bit 0 as one Manchester pair, then holds the line
        wr(`RLC_IDX_RADIO_CTRL, 8'h06);
        wr(`RLC_IDX_DATA_BUF, 8'h01);
        tgo <= 1'b1;
        @(posedge clk);
        tgo <= 1'b0;
        do @(posedge clk); while (busy === 1'b1);
        repeat (2) @(posedge clk);
        check("tx_bit", 32'h0080_0000, 32'(cap));
        complete_run();
    end
endmodule
